// ---- src/hbm_master.sv ----
// Host bus master: request queue and two-port master engine
`timescale 1ns/1ps
`default_nettype none

//------------------------------------------------------------
// Request queue
//------------------------------------------------------------
module hbm_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } hbm_fifo_st_t;

  hbm_fifo_st_t q;
  hbm_fifo_st_t d;
  logic push;
  logic pop;

  if (D < 2 || (D & (D - 1)) != 0 || W < 1) begin : g_chk
    $error("hbm_fifo: depth must be a power of two of at least 2");
  end

  // Flags and read port
  assign in_ready = q.cnt != (AW + 1)'(D);
  assign out_valid = q.cnt != '0;
  assign out_data = q.mem[q.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer and count update
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_data;
      d.wp = q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = q.rp + 1'b1;
    end
    d.cnt = q.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  // State register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

//------------------------------------------------------------
// Master engine
//------------------------------------------------------------
module hbm_master #(
  parameter int QUEUE_DEPTH = hbm_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Back-end port A
  input wire logic port_a_request_strobe_n,
  input wire hbm_pkg::hbm_req_t port_a_req,
  input wire logic [63:0] port_a_write_data,
  output hbm_pkg::hbm_ans_t port_a_ans,
  // Back-end port B
  input wire logic port_b_request_strobe_n,
  input wire hbm_pkg::hbm_req_t port_b_req,
  input wire logic [63:0] port_b_write_data,
  output hbm_pkg::hbm_ans_t port_b_ans,
  // Read data to both ports
  output logic [63:0] port_read_data,
  // Host bus
  input wire hbm_pkg::hbm_host_in_t host_in,
  output hbm_pkg::hbm_host_out_t host_out
);
  import hbm_pkg::*;

  typedef struct packed {
    hbm_host_in_t s1;
    hbm_host_in_t s2;
    hbm_state_t st;
    hbm_cmd_t cmd;
    logic [2:0] cnt;
    logic [1:0] acc;
    logic [1:0] waitv;
    logic last;
    hbm_ans_t [1:0] ans;
    logic [63:0] rdata;
    hbm_host_out_t out;
  } hbm_st_t;

  hbm_st_t q;
  hbm_st_t d;
  hbm_host_in_t hi;
  hbm_cmd_t enc_a;
  hbm_cmd_t enc_b;
  hbm_cmd_t qd;
  logic [1:0] req;
  logic [1:0] older;
  logic pick;
  logic push;
  logic in_ready;
  logic out_valid;
  logic pop;
  logic [63:0] wsel;

  if (QUEUE_DEPTH < 2) begin : g_chk
    $error("hbm_master: queue depth below 2");
  end

  // Encoders ahead of arbitration
  assign enc_a = hbm_encode(port_a_req, 1'b0);
  assign enc_b = hbm_encode(port_b_req, 1'b1);

  // Arbitration: new requests, earlier waiter first, tie to other port
  assign req = ~{port_b_request_strobe_n, port_a_request_strobe_n} & ~q.acc;
  assign older = req & q.waitv;
  assign pick = (req == 2'b11) ? ((older == 2'b01) ? 1'b0 :
                (older == 2'b10) ? 1'b1 : ~q.last) : req[1];
  assign push = (|req) && in_ready;
  assign pop = q.st == S_IDLE && out_valid;

  // Synchronised host inputs and served port data
  assign hi = q.s2;
  assign wsel = q.cmd.port ? port_b_write_data : port_a_write_data;

  hbm_fifo #(
    .W($bits(hbm_cmd_t)),
    .D(QUEUE_DEPTH)
  ) u_queue (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(|req),
    .in_ready(in_ready),
    .in_data(pick ? enc_b : enc_a),
    .out_valid(out_valid),
    .out_ready(pop),
    .out_data(qd)
  );

  // Next-state logic
  always_comb begin
    d = q;
    d.s1 = host_in;
    d.s2 = q.s1;
    d.ans = '1;
    d.out.transfer_begin_n = 1'b1;
    // Port bookkeeping
    for (int i = 0; i < 2; i++) begin
      if (!q.ans[i].done_n || !q.ans[i].err_n) begin
        d.acc[i] = 1'b0;
      end
    end
    if (push) begin
      d.acc[pick] = 1'b1;
      d.last = pick;
    end
    d.waitv = push ? (req & ~(2'b01 << pick)) : req;
    unique case (q.st)
      S_IDLE: begin
        if (out_valid) begin
          d.cmd = qd;
          d.cnt = qd.tbst_n ? BEATS_SINGLE : BEATS_BURST;
          d.out.bus_request_n = 1'b0;
          d.st = S_AREQ;
        end
      end
      S_AREQ: begin
        if (!hi.addr_grant_n && hi.addr_tenure_busy_n) begin
          d.out.bus_request_n = 1'b1;
          d.out.transfer_begin_n = 1'b0;
          d.out.abb_out_n = 1'b0;
          d.out.abb_oe = 1'b1;
          d.out.addr_oe = 1'b1;
          d.out.addr = q.cmd.addr;
          d.out.host_size_code = q.cmd.size;
          d.out.host_burst_indicator_n = q.cmd.tbst_n;
          d.out.transfer_type_code = q.cmd.wr ? XFER_WRITE : XFER_READ;
          d.st = S_ATEN;
        end
      end
      S_ATEN: begin
        if (!hi.addr_retry_n) begin
          d.out.abb_oe = 1'b0;
          d.out.addr_oe = 1'b0;
          d.out.bus_request_n = 1'b0;
          d.st = S_AREQ;
        end else if (!hi.addr_ack_n) begin
          d.out.abb_oe = 1'b0;
          d.out.addr_oe = 1'b0;
          d.st = S_DREQ;
        end
      end
      S_DREQ: begin
        if (!hi.data_grant_n && hi.data_tenure_busy_n) begin
          d.out.dbb_out_n = 1'b0;
          d.out.dbb_oe = 1'b1;
          d.out.data_oe = q.cmd.wr;
          d.st = S_DTEN;
        end
      end
      S_DTEN: begin
        if (!hi.transfer_error_ack_n) begin
          d.ans[q.cmd.port].err_n = 1'b0;
          d.out.dbb_oe = 1'b0;
          d.out.data_oe = 1'b0;
          d.st = S_IDLE;
        end else if (!hi.transfer_ack_n) begin
          d.ans[q.cmd.port].rdy_n = 1'b0;
          d.rdata = hi.read_data;
          d.cnt = q.cnt - 3'h1;
          if (q.cnt == 3'h1) begin
            d.ans[q.cmd.port].done_n = 1'b0;
            d.out.dbb_oe = 1'b0;
            d.out.data_oe = 1'b0;
            d.st = S_IDLE;
          end
        end
      end
    endcase
    // Write data halves
    d.out.host_data_upper = wsel[63:32];
    d.out.host_data_lower = wsel[31:0];
  end

  // State register; active-low outputs high under reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.s1 <= '1;
      q.s2 <= '1;
      q.s1.read_data <= '0;
      q.s2.read_data <= '0;
      q.st <= S_IDLE;
      q.ans <= '1;
      q.out.bus_request_n <= OUT_N_RST;
      q.out.transfer_begin_n <= OUT_N_RST;
      q.out.host_burst_indicator_n <= OUT_N_RST;
      q.out.cache_inhibit_n <= OUT_N_RST;
      q.out.write_through_n <= OUT_N_RST;
      q.out.global_snoop_n <= OUT_N_RST;
      q.out.abb_out_n <= OUT_N_RST;
      q.out.dbb_out_n <= OUT_N_RST;
    end else begin
      q <= d;
    end
  end

  // Outputs
  assign port_a_ans = q.ans[0];
  assign port_b_ans = q.ans[1];
  assign port_read_data = q.rdata;
  assign host_out = q.out;

  //------------------------------------------------------------
  // Checks
  //------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence s_retry_seen;
    q.st == S_ATEN && !hi.addr_retry_n;
  endsequence

  sequence s_rerequest;
    q.st == S_AREQ && !q.out.bus_request_n;
  endsequence

  sequence s_last_beat;
    q.st == S_DTEN && hi.transfer_error_ack_n && !hi.transfer_ack_n && q.cnt == 3'h1;
  endsequence

  chk_addr_grant_gate: assert property (
    $fell(q.out.transfer_begin_n) |-> !$past(hi.addr_grant_n))
    else $error("transfer began without address grant");
  chk_addr_busy_gate: assert property (
    $rose(q.out.abb_oe) |-> $past(hi.addr_tenure_busy_n))
    else $error("address tenure taken while bus busy");
  chk_data_busy_gate: assert property (
    $rose(q.out.dbb_oe) |-> $past(hi.data_tenure_busy_n) && !$past(hi.data_grant_n))
    else $error("data tenure taken without free granted bus");
  chk_idle_leave: assert property (
    q.st == S_IDLE && !out_valid |=> q.st == S_IDLE)
    else $error("machine left idle without a request");
  chk_retry_repeat: assert property (
    s_retry_seen |=> s_rerequest ##0 !q.out.abb_oe)
    else $error("retry did not release and request again");
  chk_error_pulse: assert property (
    q.st == S_DTEN && !hi.transfer_error_ack_n |=>
      q.st == S_IDLE && !q.ans[q.cmd.port].err_n ##1 q.ans[q.cmd.port].err_n)
    else $error("error end not pulsed to port");
  chk_last_beat_done: assert property (
    s_last_beat |=> q.st == S_IDLE && !q.ans[q.cmd.port].done_n && !q.out.dbb_oe)
    else $error("last beat did not finish operation");
  chk_beat_ready: assert property (
    q.st == S_DTEN && hi.transfer_error_ack_n && !hi.transfer_ack_n
      |=> !q.ans[q.cmd.port].rdy_n)
    else $error("moved beat without ready pulse");
  chk_tie_fair: assert property (
    push && req == 2'b11 && q.waitv == 2'b00 |-> pick != q.last)
    else $error("tie not given to other port");
  chk_reset_idle: assert property (@(posedge clk_sys) disable iff (1'b0)
    rst |=> q.st == S_IDLE && q.out.bus_request_n && q.out.transfer_begin_n)
    else $error("outputs active during reset");
endmodule

`default_nettype wire

// ---- src/hbm_pkg.sv ----
// Package: constants, types and size encoder of the host bus master
//------------------------------------------------------------
// Functional notes
// - Back-end ports are served in the order their requests arrive.
// - On a same-cycle tie, the port not served last goes first.
// - Each port's single-beat size code and low address bits come from its byte enables.
// - Control machine leaves idle only for a queued request.
// - Control machine returns idle on completion or abnormal end.
// - A beat counter marks the last data beat of a transfer.
// - The address bus is requested; address and data buses are held as separate tenures.
// - A tenure starts only after its own grant is received.
// - A grant counts only while that bus's busy line shows it free.
// - Address retry requests the address bus again; transfer error ends the current operation.
// - The port's burst request picks a burst or a single-beat transfer.
// - An error end pulses the requesting port's active-low error output.
// - Each moved beat pulses ready; a finished operation pulses done.
// - The 64-bit write data drives the upper and lower host halves.
//------------------------------------------------------------
package hbm_pkg;
  localparam logic [2:0] BEATS_BURST = 3'h4;
  localparam logic [2:0] BEATS_SINGLE = 3'h1;
  localparam logic [2:0] SIZE_BURST = 3'h2;
  localparam logic [4:0] XFER_WRITE = 5'h02;
  localparam logic [4:0] XFER_READ = 5'h0A;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam logic OUT_N_RST = 1'h1;

  typedef enum logic [2:0] {S_IDLE, S_AREQ, S_ATEN, S_DREQ, S_DTEN} hbm_state_t;

  typedef struct packed {
    logic [28:0] addr;
    logic wr;
    logic burst_n;
    logic [7:0] be_n;
  } hbm_req_t;

  typedef struct packed {
    logic [31:0] addr;
    logic wr;
    logic tbst_n;
    logic [2:0] size;
    logic port;
  } hbm_cmd_t;

  typedef struct packed {
    logic rdy_n;
    logic done_n;
    logic err_n;
  } hbm_ans_t;

  typedef struct packed {
    logic addr_grant_n;
    logic data_grant_n;
    logic addr_tenure_busy_n;
    logic data_tenure_busy_n;
    logic addr_ack_n;
    logic addr_retry_n;
    logic transfer_ack_n;
    logic transfer_error_ack_n;
    logic [63:0] read_data;
  } hbm_host_in_t;

  typedef struct packed {
    logic bus_request_n;
    logic transfer_begin_n;
    logic [31:0] addr;
    logic addr_oe;
    logic [2:0] host_size_code;
    logic host_burst_indicator_n;
    logic [4:0] transfer_type_code;
    logic cache_inhibit_n;
    logic write_through_n;
    logic global_snoop_n;
    logic abb_out_n;
    logic abb_oe;
    logic dbb_out_n;
    logic dbb_oe;
    logic [31:0] host_data_upper;
    logic [31:0] host_data_lower;
    logic data_oe;
  } hbm_host_out_t;

  // Size encoder: byte enable i selects byte offset i
  function automatic hbm_cmd_t hbm_encode(hbm_req_t r, logic port);
    hbm_cmd_t c;
    logic [3:0] n;
    logic [2:0] lo;
    c = '0;
    n = 4'h0;
    lo = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (!r.be_n[i]) begin
        lo = 3'(i);
      end
      n = n + 4'(!r.be_n[i]);
    end
    c.wr = r.wr;
    c.port = port;
    c.tbst_n = r.burst_n;
    c.size = r.burst_n ? n[2:0] : SIZE_BURST;
    c.addr = {r.addr, r.burst_n ? lo : 3'h0};
    return c;
  endfunction
endpackage

// ---- verification/hbm_host_model.sv ----
// Host bus model: arbiter and slave facing the master engine
`timescale 1ns/1ps
`default_nettype none
module hbm_host_model (
  // Clock, reset and scenario controls
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic retry_once,
  input wire logic error_once,
  input wire logic [2:0] delay,
  // Host bus
  input wire hbm_pkg::hbm_host_out_t host_out,
  output hbm_pkg::hbm_host_in_t host_in,
  // Observations
  output hbm_pkg::hbm_host_out_t cmd,
  output logic [63:0] wdata,
  output int ts_cnt,
  output int viol_cnt
);
  import hbm_pkg::*;
  hbm_host_in_t drv = '1;
  int ga = 0;
  int da = 0;
  int n;
  logic oe_was = 1'b0;
  logic retried = 1'b0;

  // Busy lines: other master's hold and-ed with the engine's own drive
  always_comb begin
    host_in = drv;
    host_in.addr_tenure_busy_n = drv.addr_tenure_busy_n & (host_out.abb_out_n | !host_out.abb_oe);
    host_in.data_tenure_busy_n = drv.data_tenure_busy_n & (host_out.dbb_out_n | !host_out.dbb_oe);
  end

  // One cycle; tenures may start only three cycles into a qualified grant
  task automatic tick();
    @(posedge clk_sys);
    #1;
    ga = (drv.addr_grant_n || !drv.addr_tenure_busy_n) ? 0 : ga + 1;
    da = (drv.data_grant_n || !drv.data_tenure_busy_n) ? 0 : da + 1;
    if (!host_out.transfer_begin_n && ga < 3) viol_cnt++;
    if (host_out.dbb_oe && !oe_was && da < 3) viol_cnt++;
    oe_was = host_out.dbb_oe;
  endtask

  // Grant, acknowledge and data beats, one operation at a time
  initial begin
    ts_cnt = 0;
    viol_cnt = 0;
    forever begin
      tick();
      drv.read_data = ~drv.read_data; // Released data lines keep moving
      if (!rst && !host_out.bus_request_n) begin
        drv.addr_grant_n = 1'b0;
        drv.addr_tenure_busy_n = 1'b0; // Other master still owns the bus
        repeat (delay) tick();
        drv.addr_tenure_busy_n = 1'b1;
        for (n = 0; n < 40 && host_out.transfer_begin_n; n++) tick();
        drv.addr_grant_n = 1'b1;
        if (host_out.transfer_begin_n) continue;
        cmd = host_out;
        ts_cnt++;
        retried = retry_once && !retried;
        drv.addr_retry_n = !retried;
        drv.addr_ack_n = retried;
        tick();
        drv.addr_retry_n = 1'b1;
        drv.addr_ack_n = 1'b1;
        if (retried) continue;
        drv.data_grant_n = 1'b0;
        drv.data_tenure_busy_n = 1'b0; // Other master still owns the data bus
        repeat (delay) tick();
        drv.data_tenure_busy_n = 1'b1;
        for (n = 0; n < 40 && !host_out.dbb_oe; n++) tick();
        drv.data_grant_n = 1'b1;
        for (n = 0; n < (cmd.host_burst_indicator_n ? 1 : 4); n++) begin
          repeat (3) tick();
          wdata = {host_out.host_data_upper, host_out.host_data_lower};
          drv.read_data = {cmd.addr, 32'(n)};
          drv.transfer_error_ack_n = !error_once;
          drv.transfer_ack_n = error_once;
          tick();
          drv.transfer_ack_n = 1'b1;
          drv.transfer_error_ack_n = 1'b1;
          drv.read_data = ~drv.read_data;
          if (error_once) n = 4;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- verification/hbm_master_test.sv ----
// Testbench of the two-port host bus master
`timescale 1ns/1ps
`default_nettype none
module hbm_master_test;
  import hbm_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [1:0] stb_n;
  hbm_req_t req [2];
  logic [63:0] wd [2];
  hbm_ans_t ans [2];
  logic [63:0] rdata;
  hbm_host_in_t hin;
  hbm_host_out_t hout;
  hbm_host_out_t cmd;
  logic [63:0] wdata;
  logic retry_once = 1'b0;
  logic error_once = 1'b0;
  logic [2:0] delay = 3'h0;
  int ts_cnt;
  int viol_cnt;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  int exp_ts = 0;
  int seed;
  int served[$];

  hbm_master u_hbm_master (.clk_sys(clk_sys), .rst(rst), .port_a_request_strobe_n(stb_n[0]),
    .port_a_req(req[0]), .port_a_write_data(wd[0]), .port_a_ans(ans[0]),
    .port_b_request_strobe_n(stb_n[1]), .port_b_req(req[1]), .port_b_write_data(wd[1]),
    .port_b_ans(ans[1]), .port_read_data(rdata), .host_in(hin), .host_out(hout));
  hbm_host_model u_hbm_host_model (.clk_sys(clk_sys), .rst(rst), .retry_once(retry_once),
    .error_once(error_once), .delay(delay), .host_out(hout), .host_in(hin), .cmd(cmd),
    .wdata(wdata), .ts_cnt(ts_cnt), .viol_cnt(viol_cnt));

  // Clock and cycle ceiling
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Lowest enabled byte offset and size code of a request
  function automatic logic [5:0] lo_size(hbm_req_t r);
    logic [2:0] lo;
    logic [2:0] cnt;
    lo = 3'h0;
    cnt = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      cnt = cnt + 3'(!r.be_n[i]);
      if (!r.be_n[i]) lo = 3'(i);
    end
    return r.burst_n ? {lo, cnt} : 6'h02;
  endfunction

  function automatic hbm_req_t rnd_req();
    hbm_req_t r;
    r = hbm_req_t'(39'($random(seed)));
    if (r.be_n == 8'hFF) r.be_n = 8'h7F;
    return r;
  endfunction

  // One request on a port, answered and compared beat by beat
  task automatic run_op(input int p, input hbm_req_t r, input logic [63:0] d, input logic e);
    int n;
    int b;
    logic [5:0] ls;
    ls = lo_size(r);
    b = 0;
    n = 0;
    @(posedge clk_sys);
    req[p] <= r;
    wd[p] <= d;
    stb_n[p] <= 1'b0;
    do begin
      @(negedge clk_sys);
      n++;
      if (ans[p].rdy_n === 1'b0) begin
        if (!r.wr) check("read data", rdata, {r.addr, ls[5:3], 32'(b)});
        b++;
      end
    end while (ans[p].done_n === 1'b1 && ans[p].err_n === 1'b1 && n < 400);
    served.push_back(p);
    exp_ts += 1 + 32'(retry_once);
    check("done", ans[p].done_n, e);
    check("error", ans[p].err_n, !e);
    check("beats", b, e ? 0 : (r.burst_n ? 1 : 4));
    check("address", cmd.addr, {r.addr, ls[5:3]});
    check("size", {cmd.host_burst_indicator_n, cmd.host_size_code}, {r.burst_n, ls[2:0]});
    check("type", cmd.transfer_type_code, r.wr ? XFER_WRITE : XFER_READ);
    check("attributes", {cmd.cache_inhibit_n, cmd.write_through_n, cmd.global_snoop_n}, 3'h7);
    if (r.wr && !e) check("write data", wdata, d);
    @(posedge clk_sys);
    stb_n[p] <= 1'b1;
  endtask

  // Reset, corner cases, retry, error, arrival order, random pairs
  initial begin
    seed = 32'hD1C9C7B8;
    stb_n = 2'b11;
    req = '{default: '1};
    wd = '{default: '0};
    repeat (5) @(negedge clk_sys);
    check("reset outputs", {hout.bus_request_n, hout.transfer_begin_n, ans[0], ans[1]}, 8'hFF);
    @(posedge clk_sys);
    rst <= 1'b0;
    run_op(0, '{29'h10, 1'b1, 1'b1, 8'h00}, 64'h0123_4567_89AB_CDEF, 1'b0);
    run_op(1, '{29'h1FFF_FFFF, 1'b0, 1'b1, 8'h7F}, 64'h0, 1'b0);
    run_op(0, '{29'h20, 1'b1, 1'b0, 8'h00}, 64'hFEDC_BA98_7654_3210, 1'b0);
    retry_once <= 1'b1;
    run_op(1, '{29'h30, 1'b0, 1'b0, 8'h0F}, 64'h0, 1'b0);
    retry_once <= 1'b0;
    error_once <= 1'b1;
    run_op(1, '{29'h40, 1'b0, 1'b0, 8'h00}, 64'h0, 1'b1);
    error_once <= 1'b0;
    fork
      begin
        run_op(0, rnd_req(), 64'h1111_2222_3333_4444, 1'b0);
        run_op(0, rnd_req(), 64'h5555_6666_7777_8888, 1'b0);
      end
      begin
        repeat (3) @(posedge clk_sys);
        run_op(1, rnd_req(), 64'h9999_AAAA_BBBB_CCCC, 1'b0);
      end
    join
    check("arrival order", {1'(served[$-2]), 1'(served[$-1]), 1'(served[$])}, 3'b010);
    for (int i = 0; i < 12; i++) begin
      @(posedge clk_sys);
      delay <= 3'($random(seed));
      fork
        run_op(0, rnd_req(), {$random(seed), $random(seed)}, 1'b0);
        run_op(1, rnd_req(), {$random(seed), $random(seed)}, 1'b0);
      join
      check("tie order", served[$-1], !served[$-2]);
    end
    check("tenure starts", ts_cnt, exp_ts);
    check("grant misuse", viol_cnt, 0);
    print_verdict();
  end
endmodule
`default_nettype wire
